// [hw/supply_fault_response_retry.sv]
/*
 Two-channel fault reaction and retry engine for converter-sampled faults and turn-on limit faults.
 Assumes fault inputs are synchronous levels from the converter and sequencer, and a host
 command port that writes and reads configuration bytes and words by selector and page.
*/
`timescale 1ns/10ps
module supply_fault_response_retry #(
   parameter int QUIET_TICKS = fault_reaction_pkg::QUIET_TICKS,
   parameter int SHARE_EDGES = fault_reaction_pkg::SHARE_EDGES_PER_TICK
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic share_clk,
   input wire logic cfg_wr,
   input wire logic [2:0] cfg_sel,
   input wire logic cfg_page,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   input wire logic clear_faults,
   input wire logic [1:0] overtemp_fault,
   input wire logic [1:0] undertemp_fault,
   input wire logic input_high_fault,
   input wire logic input_low_fault,
   input wire logic [1:0] turn_on_limit_fault,
   input wire logic [1:0] chan_on_cmd,
   input wire logic [1:0] track_en,
   input wire logic bias_ok,
   output logic [1:0] chan_run,
   output logic [1:0] chan_seq_off,
   output logic [1:0] chan_faulted_off,
   output logic [1:0] overtemp_flag,
   output logic [1:0] undertemp_flag,
   output logic input_high_flag,
   output logic input_low_flag,
   output logic [1:0] turn_on_limit_flag,
   output logic temp_summary_flag,
   output logic input_summary_flag,
   output logic vout_summary_flag,
   output logic host_alert_n
);
   localparam int NC = fault_reaction_pkg::NUM_CHAN;
   localparam int NF = fault_reaction_pkg::NUM_FAULT;

   logic [4:0] react [0:NC-1][0:NF-1];
   logic [15:0] delay_raw;
   logic [2:0] retry_count;
   logic [15:0] delay_ticks;
   logic tick;

   logic [1:0] ot_prev;
   logic [1:0] ut_prev;
   logic vov_prev;
   logic vuv_prev;
   logic [1:0] ton_prev;
   logic [NF-1:0] ev [0:NC-1];

   fault_reaction_pkg::chan_state_t state [0:NC-1];
   logic [NF-1:0] lat_restart [0:NC-1];
   logic [2:0] lat_count [0:NC-1];
   logic [2:0] used [0:NC-1];
   logic [15:0] wait_cnt [0:NC-1];
   logic [16:0] quiet_cnt [0:NC-1];
   logic [1:0] on_prev;
   logic [NC-1:0] shut_req;
   logic [NC-1:0] retry_ok;

   share_tick_gen #(
      .EDGES(SHARE_EDGES)
   ) u_tick (
      .clk(clk),
      .sys_rst(sys_rst),
      .share_clk(share_clk),
      .tick(tick)
   );

   retry_interval_conv u_conv (
      .clk(clk),
      .sys_rst(sys_rst),
      .raw(delay_raw),
      .ticks(delay_ticks)
   );

   // Configuration storage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int c = 0; c < NC; c++) begin
            for (int f = 0; f < NF; f++) begin
               react[c][f] <= fault_reaction_pkg::REACT_RESET;
            end
         end
         delay_raw <= fault_reaction_pkg::DELAY_RESET;
         retry_count <= fault_reaction_pkg::COUNT_RESET;
      end else if (cfg_wr) begin
         if (cfg_sel <= fault_reaction_pkg::SEL_TON) begin
            react[cfg_page][cfg_sel] <= cfg_wdata[7:3];
         end
         if (cfg_sel == fault_reaction_pkg::SEL_DELAY) begin
            delay_raw <= cfg_wdata;
         end
         if (cfg_sel == fault_reaction_pkg::SEL_COUNT) begin
            retry_count <= cfg_wdata[2:0];
         end
      end
   end

   // Registered read data; unknown selectors read zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_rdata <= 16'h0000;
      end else begin
         cfg_rdata <= 16'h0000;
         if (cfg_sel <= fault_reaction_pkg::SEL_TON) begin
            cfg_rdata <= {8'h00, react[cfg_page][cfg_sel], fault_reaction_pkg::DEGLITCH_VALUE};
         end else if (cfg_sel == fault_reaction_pkg::SEL_DELAY) begin
            cfg_rdata <= delay_raw;
         end else if (cfg_sel == fault_reaction_pkg::SEL_COUNT) begin
            cfg_rdata <= {13'h0000, retry_count};
         end
      end
   end

   // Fault event edges; no deglitch so a fault acts the cycle after it rises
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ot_prev <= 2'h0;
         ut_prev <= 2'h0;
         vov_prev <= 1'b0;
         vuv_prev <= 1'b0;
         ton_prev <= 2'h0;
         on_prev <= 2'h0;
      end else begin
         ot_prev <= overtemp_fault;
         ut_prev <= undertemp_fault;
         vov_prev <= input_high_fault;
         vuv_prev <= input_low_fault;
         ton_prev <= turn_on_limit_fault;
         on_prev <= chan_on_cmd;
      end
   end

   always_comb begin
      for (int c = 0; c < NC; c++) begin
         ev[c] = {turn_on_limit_fault[c] & ~ton_prev[c], input_low_fault & ~vuv_prev,
                  input_high_fault & ~vov_prev, undertemp_fault[c] & ~ut_prev[c],
                  overtemp_fault[c] & ~ot_prev[c]};
      end
   end

   always_comb begin
      for (int c = 0; c < NC; c++) begin
         shut_req[c] = 1'b0;
         retry_ok[c] = 1'b1;
         for (int f = 0; f < NF; f++) begin
            if (ev[c][f] && fault_reaction_pkg::action_on(react[c][f])) begin
               shut_req[c] = 1'b1;
               if (!lat_restart[c][f]) begin
                  retry_ok[c] = 1'b0;
               end
            end
         end
         if (lat_count[c] != fault_reaction_pkg::COUNT_UNLIMITED && used[c] >= lat_count[c]) begin
            retry_ok[c] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int c = 0; c < NC; c++) begin
            state[c] <= fault_reaction_pkg::ST_OFF;
            lat_restart[c] <= '0;
            lat_count[c] <= 3'h0;
            used[c] <= 3'h0;
            wait_cnt[c] <= 16'h0000;
            quiet_cnt[c] <= 17'h00000;
         end
      end else begin
         for (int c = 0; c < NC; c++) begin
            if (state[c] == fault_reaction_pkg::ST_ON) begin
               if (quiet_cnt[c] >= 17'(QUIET_TICKS)) begin
                  used[c] <= 3'h0;
               end else if (tick) begin
                  quiet_cnt[c] <= quiet_cnt[c] + 17'h00001;
               end
            end else begin
               quiet_cnt[c] <= 17'h00000;
            end
            // Off command or bias loss ends everything
            if (!bias_ok || !chan_on_cmd[c]) begin
               state[c] <= fault_reaction_pkg::ST_OFF;
               used[c] <= 3'h0;
            end else begin
               case (state[c])
                  fault_reaction_pkg::ST_OFF: begin
                     state[c] <= fault_reaction_pkg::ST_ON;
                     for (int f = 0; f < NF; f++) begin
                        lat_restart[c][f] <= fault_reaction_pkg::restart_on(react[c][f]);
                     end
                     lat_count[c] <= retry_count;
                  end
                  fault_reaction_pkg::ST_ON: begin
                     if (shut_req[c]) begin
                        if (retry_ok[c]) begin
                           state[c] <= fault_reaction_pkg::ST_RETRY_WAIT;
                           wait_cnt[c] <= delay_ticks;
                           if (lat_count[c] != fault_reaction_pkg::COUNT_UNLIMITED) begin
                              used[c] <= used[c] + 3'h1;
                           end
                        end else begin
                           state[c] <= fault_reaction_pkg::ST_FAULT_OFF;
                        end
                     end
                  end
                  fault_reaction_pkg::ST_RETRY_WAIT: begin
                     if (shut_req[c]) begin
                        state[c] <= fault_reaction_pkg::ST_FAULT_OFF;
                     end else if (wait_cnt[c] == 16'h0000) begin
                        state[c] <= fault_reaction_pkg::ST_ON;
                     end else if (tick) begin
                        wait_cnt[c] <= wait_cnt[c] - 16'h0001;
                     end
                  end
                  fault_reaction_pkg::ST_FAULT_OFF: begin
                     // Only an off command or bias loss releases this
                     state[c] <= fault_reaction_pkg::ST_FAULT_OFF;
                  end
                  default: begin
                     state[c] <= fault_reaction_pkg::ST_OFF;
                  end
               endcase
            end
         end
      end
   end

   // Channel outputs; shutdown mode follows tracking at the moment of shutdown
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chan_run <= 2'h0;
         chan_seq_off <= 2'h0;
         chan_faulted_off <= 2'h0;
      end else begin
         for (int c = 0; c < NC; c++) begin
            chan_run[c] <= (state[c] == fault_reaction_pkg::ST_ON);
            chan_faulted_off[c] <= (state[c] == fault_reaction_pkg::ST_FAULT_OFF)
                                   || (state[c] == fault_reaction_pkg::ST_RETRY_WAIT);
            if (state[c] == fault_reaction_pkg::ST_ON && shut_req[c]) begin
               chan_seq_off[c] <= track_en[c];
            end
         end
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         overtemp_flag <= 2'h0;
         undertemp_flag <= 2'h0;
         input_high_flag <= 1'b0;
         input_low_flag <= 1'b0;
         turn_on_limit_flag <= 2'h0;
         temp_summary_flag <= 1'b0;
         input_summary_flag <= 1'b0;
         vout_summary_flag <= 1'b0;
      end else begin
         // Set regardless of action, hold until cleared
         for (int c = 0; c < NC; c++) begin
            overtemp_flag[c] <= ev[c][0] | (overtemp_flag[c] & ~clear_faults);
            undertemp_flag[c] <= ev[c][1] | (undertemp_flag[c] & ~clear_faults);
            turn_on_limit_flag[c] <= ev[c][4] | (turn_on_limit_flag[c] & ~clear_faults);
         end
         input_high_flag <= ev[0][2] | (input_high_flag & ~clear_faults);
         input_low_flag <= ev[0][3] | (input_low_flag & ~clear_faults);
         temp_summary_flag <= ev[0][0] | ev[0][1] | ev[1][0] | ev[1][1]
                              | (temp_summary_flag & ~clear_faults);
         input_summary_flag <= ev[0][2] | ev[0][3] | (input_summary_flag & ~clear_faults);
         vout_summary_flag <= ev[0][4] | ev[1][4] | (vout_summary_flag & ~clear_faults);
      end
   end

   // Alert follows the flags one cycle later
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_alert_n <= 1'b1;
      end else begin
         host_alert_n <= ~(|overtemp_flag | |undertemp_flag | input_high_flag | input_low_flag
                           | |turn_on_limit_flag);
      end
   end

   property p_alert;
      @(posedge clk) disable iff (sys_rst)
      (|overtemp_flag || |undertemp_flag || input_high_flag || input_low_flag) |=> !host_alert_n;
   endproperty
   a_alert: assert property (p_alert) else $error("alert not asserted after fault flag");
   property p_ton_alert;
      @(posedge clk) disable iff (sys_rst)
      (turn_on_limit_fault[0] && !ton_prev[0]) |=> (turn_on_limit_flag[0] && vout_summary_flag) ##1 !host_alert_n;
   endproperty
   a_ton_alert: assert property (p_ton_alert) else $error("turn-on limit fault not reported");
   property p_sticky;
      @(posedge clk) disable iff (sys_rst)
      (overtemp_flag[0] && !clear_faults) |=> overtemp_flag[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status flag dropped without clear");
   property p_clear_keeps_off;
      @(posedge clk) disable iff (sys_rst)
      (clear_faults && state[0] == fault_reaction_pkg::ST_FAULT_OFF && bias_ok && chan_on_cmd[0])
      |=> state[0] == fault_reaction_pkg::ST_FAULT_OFF;
   endproperty
   a_clear_keeps_off: assert property (p_clear_keeps_off) else $error("clear released fault-off");
   property p_bias_stop;
      @(posedge clk) disable iff (sys_rst)
      !bias_ok |=> state[0] == fault_reaction_pkg::ST_OFF ##1 !chan_run[0];
   endproperty
   a_bias_stop: assert property (p_bias_stop) else $error("bias loss did not stop channel");
   property p_off_clears_count;
      @(posedge clk) disable iff (sys_rst)
      (!chan_on_cmd[0] && on_prev[0]) |=> used[0] == 3'h0;
   endproperty
   a_off_clears_count: assert property (p_off_clears_count) else $error("retry count not cleared");
   property p_readback_zero;
      @(posedge clk) disable iff (sys_rst)
      $past(cfg_sel) <= fault_reaction_pkg::SEL_TON |-> cfg_rdata[2:0] == 3'h0;
   endproperty
   a_readback_zero: assert property (p_readback_zero) else $error("deglitch bits read nonzero");
   property p_delay_readback;
      @(posedge clk) disable iff (sys_rst)
      (cfg_wr && cfg_sel == fault_reaction_pkg::SEL_DELAY) ##1 (!cfg_wr && cfg_sel == fault_reaction_pkg::SEL_DELAY)
      |=> cfg_rdata == $past(cfg_wdata, 2);
   endproperty
   a_delay_readback: assert property (p_delay_readback) else $error("retry interval readback differs");
   property p_latched_off;
      @(posedge clk) disable iff (sys_rst)
      (state[0] == fault_reaction_pkg::ST_FAULT_OFF) [*2] |-> !chan_run[0] && chan_faulted_off[0];
   endproperty
   a_latched_off: assert property (p_latched_off) else $error("fault-off channel running");
   property p_ignore_action;
      @(posedge clk) disable iff (sys_rst)
      (state[0] == fault_reaction_pkg::ST_ON && bias_ok && chan_on_cmd[0] && !shut_req[0])
      |=> state[0] == fault_reaction_pkg::ST_ON;
   endproperty
   a_ignore_action: assert property (p_ignore_action) else $error("channel stopped without shutdown");
   property p_retry_limit;
      @(posedge clk) disable iff (sys_rst)
      lat_count[0] != fault_reaction_pkg::COUNT_UNLIMITED |-> used[0] <= lat_count[0];
   endproperty
   a_retry_limit: assert property (p_retry_limit) else $error("retries exceed count");
endmodule : supply_fault_response_retry

// [shared/fault_reaction_pkg.sv]
/*
 Constants, selector codes and helper functions for the supply fault reaction block.
 Assumes a 100 MHz system clock and a 200 us retry tick made from the shared clock.
 //Function
 //- Temperature and input-voltage reactions act on converter-sampled fault inputs only.
 //- Any temperature or input fault sets summary and detail status bits.
 //- Every temperature or input fault pulls the active-low alert output low.
 //- Action field 00b keeps the channel running through the fault.
 //- Action 01b-11b shuts the channel off, immediate or sequenced per tracking.
 //- Restart field 000b latches the channel off until cleared.
 //- Nonzero restart field allows restarts up to the global retry count.
 //- Off command, bias loss or another fault shutdown stop retrying.
 //- Restart settings are latched at the channel's turn-on.
 //- Deglitch field bits 2:0 read 000b and add no delay.
 //- Turn-on limit fault sets high-byte, output-voltage and turn-on limit bits.
 //- Turn-on limit fault also pulls the alert output low.
 //- Turn-on limit reaction uses the same action and restart encodings.
 //- Each restart waits the programmed retry interval first.
 //- Retry interval is timed only by shared clock periods.
 //- Interval clamped to 13.1 s and rounded to nearest 200 us.
 //- Retry interval reads back exactly the last written value.
 //- Retry count 0 none, 1-6 that many, 7 unlimited.
 //- Retry counter clears after 16 s without fault-off, or off-then-on.
 //- Latched fault-off clears on control toggle, operation command or bias cycle.
 //- Clear-faults resets status and alert but keeps fault-off state.
*/
package fault_reaction_pkg;
   localparam int NUM_CHAN = 2;
   localparam int NUM_FAULT = 5;
   // Configuration selector codes
   localparam logic [2:0] SEL_OT = 3'h0;
   localparam logic [2:0] SEL_UT = 3'h1;
   localparam logic [2:0] SEL_VIN_OV = 3'h2;
   localparam logic [2:0] SEL_VIN_UV = 3'h3;
   localparam logic [2:0] SEL_TON = 3'h4;
   localparam logic [2:0] SEL_DELAY = 3'h5;
   localparam logic [2:0] SEL_COUNT = 3'h6;
   // Field positions inside a reaction byte
   localparam int ACTION_MSB = 7;
   localparam int ACTION_LSB = 6;
   localparam int RESTART_MSB = 5;
   localparam int RESTART_LSB = 3;
   localparam logic [2:0] DEGLITCH_VALUE = 3'h0;
   localparam logic [2:0] COUNT_UNLIMITED = 3'h7;
   // Reset values
   localparam logic [4:0] REACT_RESET = 5'h00;
   localparam logic [15:0] DELAY_RESET = 16'hF320;
   localparam logic [2:0] COUNT_RESET = 3'h0;
   // Timing
   localparam int TICK_US = 200;
   localparam int MAX_DELAY_MS = 13100;
   localparam logic [15:0] MAX_TICKS = 16'(MAX_DELAY_MS * 1000 / TICK_US);
   localparam int TICKS_PER_MS = 1000 / TICK_US;
   localparam int QUIET_TIME_MS = 16000;
   localparam int QUIET_TICKS = QUIET_TIME_MS * 1000 / TICK_US;
   localparam int SHARE_EDGES_PER_TICK = 20;

   typedef enum logic [1:0] {ST_OFF, ST_ON, ST_FAULT_OFF, ST_RETRY_WAIT} chan_state_t;

   // Stored reaction bits are byte bits 7:3
   function automatic logic action_on(input logic [4:0] r);
      action_on = (r[ACTION_MSB-3:ACTION_LSB-3] != 2'h0);
   endfunction : action_on

   function automatic logic restart_on(input logic [4:0] r);
      restart_on = (r[RESTART_MSB-3:RESTART_LSB-3] != 3'h0);
   endfunction : restart_on
endpackage : fault_reaction_pkg

// [hw/share_tick_gen.sv]
/*
 Retry tick generator: one pulse per fixed number of shared clock rising edges.
 Assumes share_clk is sampled as a synchronous level on clk.
*/
`timescale 1ns/10ps
module share_tick_gen #(
   parameter int EDGES = fault_reaction_pkg::SHARE_EDGES_PER_TICK
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic share_clk,
   output logic tick
);
   logic share_prev;
   logic [15:0] edge_cnt;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         share_prev <= 1'b0;
         edge_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         share_prev <= share_clk;
         tick <= 1'b0;
         if (share_clk && !share_prev) begin
            if (edge_cnt == 16'(EDGES - 1)) begin
               edge_cnt <= 16'h0000;
               tick <= 1'b1;
            end else begin
               edge_cnt <= edge_cnt + 16'h0001;
            end
         end
      end
   end
endmodule : share_tick_gen

// [hw/retry_interval_conv.sv]
/*
 Converts the written retry interval (linear 11-bit mantissa/exponent, in ms) into 200 us ticks.
 Assumes the raw word is held elsewhere; only the limited value lives here.
*/
`timescale 1ns/10ps
module retry_interval_conv (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] raw,
   output logic [15:0] ticks
);
   localparam int TICKS_PER_MS_L = fault_reaction_pkg::TICKS_PER_MS;

   function automatic logic [15:0] to_ticks(input logic [15:0] w);
      logic signed [10:0] mant;
      logic signed [4:0] expo;
      logic [47:0] v;
      logic [47:0] r;
      int sh;
      mant = signed'(w[10:0]);
      expo = signed'(w[15:11]);
      v = 48'(mant) * 48'(TICKS_PER_MS_L);
      sh = int'(expo);
      r = 48'h0;
      if (mant <= 0) begin
         r = 48'h0;
      end else if (sh >= 0) begin
         r = v << sh;
      end else begin
         r = (v + (48'h1 << (-sh - 1))) >> (-sh);
      end
      // Round-to-nearest above; large exponents saturate here
      if (r > 48'(fault_reaction_pkg::MAX_TICKS)) begin
         to_ticks = fault_reaction_pkg::MAX_TICKS;
      end else begin
         to_ticks = r[15:0];
      end
   endfunction : to_ticks

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ticks <= 16'h0000;
      end else begin
         ticks <= to_ticks(raw);
      end
   end
endmodule : retry_interval_conv

// [dv/share_clock_source.sv]
/*
 Model of the shared sync clock that the managed supplies share.
 Assumes the block counts its rising edges on its own clock.
*/
`timescale 1ns/10ps
module share_clock_source #(
   parameter int HALF_NS = 20
) (
   output logic share_clk
);
   initial begin
      share_clk = 1'b0;
      forever #(HALF_NS) share_clk = ~share_clk;
   end
endmodule : share_clock_source

// [dv/test_supply_fault_response_retry.sv]
/*
 Bench for supply_fault_response_retry: config port tasks, fault and retry sequences.
 Assumes share_clock_source drives the shared clock.
*/
`timescale 1ns/10ps
module test_supply_fault_response_retry;
   logic clk, sys_rst, share_clk, cfg_wr, cfg_page, clear_faults, input_high_fault, input_low_fault, bias_ok;
   logic [2:0] cfg_sel;
   logic [15:0] cfg_wdata, cfg_rdata;
   logic [1:0] overtemp_fault, undertemp_fault, turn_on_limit_fault, chan_on_cmd, track_en, chan_run;
   logic [1:0] chan_seq_off, chan_faulted_off, overtemp_flag, undertemp_flag, turn_on_limit_flag;
   logic input_high_flag, input_low_flag, temp_summary_flag, input_summary_flag, vout_summary_flag, host_alert_n;
   int fail_count = 0;
   int checks_done = 0;
   int k;
   // Small tick and quiet counts keep the run short
   supply_fault_response_retry #(.QUIET_TICKS(1000), .SHARE_EDGES(2)) i_supply_fault_response_retry (
      .clk(clk), .sys_rst(sys_rst), .share_clk(share_clk), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
      .cfg_page(cfg_page), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .clear_faults(clear_faults),
      .overtemp_fault(overtemp_fault), .undertemp_fault(undertemp_fault), .input_high_fault(input_high_fault),
      .input_low_fault(input_low_fault), .turn_on_limit_fault(turn_on_limit_fault), .chan_on_cmd(chan_on_cmd),
      .track_en(track_en), .bias_ok(bias_ok), .chan_run(chan_run), .chan_seq_off(chan_seq_off),
      .chan_faulted_off(chan_faulted_off), .overtemp_flag(overtemp_flag), .undertemp_flag(undertemp_flag),
      .input_high_flag(input_high_flag), .input_low_flag(input_low_flag), .turn_on_limit_flag(turn_on_limit_flag),
      .temp_summary_flag(temp_summary_flag), .input_summary_flag(input_summary_flag),
      .vout_summary_flag(vout_summary_flag), .host_alert_n(host_alert_n)
   );
   share_clock_source i_share_clock_source (.share_clk(share_clk));
   function automatic logic [10:0] st();
      return {overtemp_flag[0], undertemp_flag[0], input_high_flag, input_low_flag, turn_on_limit_flag[0],
              temp_summary_flag, input_summary_flag, vout_summary_flag, host_alert_n, chan_run};
   endfunction : st
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [2:0] s, input logic p, input logic [15:0] d);
      tick(1);
      cfg_wr = 1'b1;
      cfg_sel = s;
      cfg_page = p;
      cfg_wdata = d;
      tick(1);
      cfg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] s, input logic p, input logic [15:0] exp);
      cfg_sel = s;
      cfg_page = p;
      tick(2);
      check(cfg_rdata, exp);
   endtask : rd
   // Waits for chan_run to reach v; the wait must land in [lo, hi)
   task automatic wait_run(input int ch, input logic v, input int lo, input int hi);
      int n;
      n = 0;
      while (chan_run[ch] !== v && n < hi) begin
         tick(1);
         n++;
      end
      check(16'(n >= lo && n < hi), 16'h0001);
   endtask : wait_run
   task automatic fault(input int f, input logic v);
      case (f)
         0: overtemp_fault[0] = v;
         1: undertemp_fault[0] = v;
         2: input_high_fault = v;
         3: input_low_fault = v;
         default: turn_on_limit_fault[0] = v;
      endcase
   endtask : fault
   task automatic give_verdict();
      $display("checks_done %0d fail_count %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end
   initial begin
      {sys_rst, cfg_wr, cfg_sel, cfg_page, cfg_wdata, clear_faults} = {1'b1, 22'h000000};
      {overtemp_fault, undertemp_fault, input_high_fault, input_low_fault, turn_on_limit_fault} = 8'h00;
      {chan_on_cmd, track_en, bias_ok} = 5'h1D;
      tick(10);
      sys_rst = 1'b0;
      for (k = 0; k < 8; k++) rd(3'(k), 1'b0, k == 5 ? 16'hF320 : 16'h0000);
      wr(3'h0, 1'b0, 16'hFFFF);
      rd(3'h0, 1'b0, 16'h00F8);
      wr(3'h7, 1'b0, 16'hFFFF);
      rd(3'h7, 1'b0, 16'h0000);
      wr(3'h5, 1'b0, 16'h0001);
      rd(3'h5, 1'b0, 16'h0001);
      wr(3'h0, 1'b0, 16'h0000);
      for (k = 0; k < 5; k++) begin
         fault(k, 1'b1);
         tick(1);
         fault(k, 1'b0);
         tick(2);
         check(16'(st()), 16'({5'(5'h10 >> k), k < 2 ? 3'h4 : (k < 4 ? 3'h2 : 3'h1), 3'h3}));
         clear_faults = 1'b1;
         tick(1);
         clear_faults = 1'b0;
         tick(2);
         check(16'(st()), 16'h0007);
      end
      wr(3'h4, 1'b1, 16'h0040);
      turn_on_limit_fault[1] = 1'b1;
      tick(3);
      check({chan_faulted_off, chan_run, chan_seq_off}, 16'h0026);
      check({turn_on_limit_flag, vout_summary_flag, host_alert_n}, 16'h000A);
      turn_on_limit_fault[1] = 1'b0;
      clear_faults = 1'b1;
      tick(1);
      clear_faults = 1'b0;
      tick(80);
      check({chan_faulted_off, chan_run}, 16'h0009);
      chan_on_cmd[1] = 1'b0;
      tick(2);
      chan_on_cmd[1] = 1'b1;
      wait_run(1, 1'b1, 0, 10);
      wr(3'h6, 1'b0, 16'h0001);
      wr(3'h0, 1'b0, 16'h0048);
      for (k = 0; k < 3; k++) begin
         overtemp_fault[0] = 1'b1;
         tick(1);
         overtemp_fault[0] = 1'b0;
         wait_run(0, 1'b0, 0, 5);
         if (k == 1) begin
            wait_run(0, 1'b1, 30, 60);
         end else begin
            tick(80);
            check(16'(chan_faulted_off[0]), 16'h0001);
         end
         if (k == 0) begin
            chan_on_cmd[0] = 1'b0;
            tick(2);
            chan_on_cmd[0] = 1'b1;
            wait_run(0, 1'b1, 0, 10);
         end
      end
      bias_ok = 1'b0;
      tick(3);
      check(16'(chan_faulted_off), 16'h0000);
      bias_ok = 1'b1;
      wait_run(0, 1'b1, 0, 10);
      {overtemp_fault[1], undertemp_fault[1]} = 2'h3;
      tick(2);
      check({overtemp_flag, undertemp_flag, temp_summary_flag}, 16'h001D);
      give_verdict();
   end
endmodule : test_supply_fault_response_retry
